// ==== hdl/rtc_value_pkg.sv ====
// Constants for the calendar value register block: offsets, field map, reset values.
// Assumes an APB master with 32-bit data and byte addresses on a 12-bit paddr.
package rtc_value_pkg;

   // Register byte offsets, one aligned word each
   localparam logic [11:0] CTRL_OFFSET          = 12'h000;
   localparam logic [11:0] WKDY_HOURS_OFFSET    = 12'h004;
   localparam logic [11:0] MIN_SEC_OFFSET       = 12'h008;
   localparam logic [11:0] ALARM_MTH_DAY_OFFSET = 12'h00c;

   // Control word layout
   localparam int          UNLOCK_BIT   = 0;
   localparam logic        UNLOCK_RESET = 1'b0;

   // Value word selector, also the index of each word
   typedef enum logic [1:0] {
      REG_WKDY_HOURS    = 2'h0,
      REG_MIN_SEC       = 2'h1,
      REG_ALARM_MTH_DAY = 2'h2,
      REG_NONE          = 2'h3
   } value_reg_t;

   // Digit fields: weekday, hour tens/ones, min tens/ones, sec tens/ones,
   // alarm month tens/ones, alarm day tens/ones
   localparam int NUM_FIELDS = 11;
   localparam int F_WEEKDAY  = 0;
   localparam int F_HOUR_T   = 1;
   localparam int F_HOUR_O   = 2;
   localparam int F_MIN_T    = 3;
   localparam int F_MIN_O    = 4;
   localparam int F_SEC_T    = 5;
   localparam int F_SEC_O    = 6;
   localparam int F_AMTH_T   = 7;
   localparam int F_AMTH_O   = 8;
   localparam int F_ADAY_T   = 9;
   localparam int F_ADAY_O   = 10;

   localparam int FIELD_LSB   [NUM_FIELDS] = '{8, 4, 0, 12, 8, 4, 0, 12, 8, 4, 0};
   localparam int FIELD_WIDTH [NUM_FIELDS] = '{3, 2, 4, 3, 4, 3, 4, 1, 4, 2, 4};
   localparam int FIELD_MAX   [NUM_FIELDS] = '{6, 2, 9, 5, 9, 5, 9, 1, 9, 3, 9};
   localparam int FIELD_REG   [NUM_FIELDS] = '{0, 0, 0, 1, 1, 1, 1, 2, 2, 2, 2};

   localparam logic [3:0] FIELD_RESET = 4'h0;

endpackage

// ==== hdl/bcd_digit_store.sv ====
// One BCD digit of a calendar value word, held in a flop.
// Assumes the caller has already qualified the write strobe.
`timescale 1ns/1ps
module bcd_digit_store #(
   parameter int WIDTH = 4,
   parameter int MAX   = 9
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             wr_en,
   input  wire logic [3:0]       wr_data,
   output logic      [3:0]       value
);

   logic [3:0] next_value;
   logic [3:0] masked;

   always_comb begin
      // Bits above the field width are never stored
      masked     = wr_data & 4'((1 << WIDTH) - 1);
      next_value = value;
      // Out-of-range digits are dropped so the word never holds an illegal BCD code
      if (wr_en && (32'(masked) <= 32'(MAX))) begin
         next_value = masked;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         value <= rtc_value_pkg::FIELD_RESET;
      end else begin
         value <= next_value;
      end
   end

endmodule // bcd_digit_store

// ==== hdl/rtc_value_regs.sv ====
// APB slave holding the weekday/hours, minutes/seconds and alarm month/day words.
// Assumes an APB master on pclk; the tick and alarm matching logic live elsewhere.
`timescale 1ns/1ps

// Overview of operation
// - Weekday/hours and alarm month/day writes take effect only while unlock is 1.
// - Minute tens digit sits in bits 14-12, values 0 to 5.
// - Minute ones digit sits in bits 11-8, values 0 to 9.
// - Second ones digit sits in bits 3-0, values 0 to 9.
// - Alarm month tens digit is the single bit 12, 0 or 1.
// - Alarm month ones digit sits in bits 11-8, values 0 to 9.
// - Alarm day tens digit sits in bits 5-4, values 0 to 3.
// - Alarm day ones digit sits in bits 3-0, values 0 to 9.
// - Weekday sits in bits 10-8 of weekday/hours, values 0 to 6.
// - Hour tens digit sits in bits 5-4 of weekday/hours, values 0 to 2.
module rtc_value_regs (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             calendar_write_unlock,
   output logic      [15:0] weekday_hours_value,
   output logic      [15:0] minutes_seconds_value,
   output logic      [15:0] alarm_month_day_value
);

   logic [3:0]                     field_value [rtc_value_pkg::NUM_FIELDS];
   logic [rtc_value_pkg::NUM_FIELDS-1:0] field_wr;
   rtc_value_pkg::value_reg_t       sel_reg;
   logic                            sel_ctrl;
   logic                            mapped;
   logic                            commit;
   logic                            next_pready;
   logic                            next_pslverr;
   logic [31:0]                     next_prdata;
   logic                            next_unlock;
   logic [15:0]                     wkdy_word;
   logic [15:0]                     min_sec_word;
   logic [15:0]                     alarm_word;

   // Address decode
   always_comb begin
      sel_reg  = rtc_value_pkg::REG_NONE;
      sel_ctrl = 1'b0;
      case (paddr)
         rtc_value_pkg::CTRL_OFFSET:          sel_ctrl = 1'b1;
         rtc_value_pkg::WKDY_HOURS_OFFSET:    sel_reg  = rtc_value_pkg::REG_WKDY_HOURS;
         rtc_value_pkg::MIN_SEC_OFFSET:       sel_reg  = rtc_value_pkg::REG_MIN_SEC;
         rtc_value_pkg::ALARM_MTH_DAY_OFFSET: sel_reg  = rtc_value_pkg::REG_ALARM_MTH_DAY;
         default:                             sel_reg  = rtc_value_pkg::REG_NONE;
      endcase
      mapped = sel_ctrl || (sel_reg != rtc_value_pkg::REG_NONE);
   end

   // A write lands only on the edge where the master sees pready
   assign commit = psel && penable && pready && pwrite && mapped;

   // Word images are plain wiring of the digit flops; spare bits tied low
   assign wkdy_word    = {5'h00, field_value[rtc_value_pkg::F_WEEKDAY][2:0],
                          2'h0, field_value[rtc_value_pkg::F_HOUR_T][1:0],
                          field_value[rtc_value_pkg::F_HOUR_O]};
   assign min_sec_word = {1'b0, field_value[rtc_value_pkg::F_MIN_T][2:0],
                          field_value[rtc_value_pkg::F_MIN_O],
                          1'b0, field_value[rtc_value_pkg::F_SEC_T][2:0],
                          field_value[rtc_value_pkg::F_SEC_O]};
   assign alarm_word   = {3'h0, field_value[rtc_value_pkg::F_AMTH_T][0],
                          field_value[rtc_value_pkg::F_AMTH_O],
                          2'h0, field_value[rtc_value_pkg::F_ADAY_T][1:0],
                          field_value[rtc_value_pkg::F_ADAY_O]};

   // Per-digit write qualification and storage
   genvar gi;
   generate
      for (gi = 0; gi < rtc_value_pkg::NUM_FIELDS; gi++) begin : g_digit
         localparam int LSB  = rtc_value_pkg::FIELD_LSB[gi];
         localparam int REGN = rtc_value_pkg::FIELD_REG[gi];
         // Only the minutes/seconds word stays writable while locked
         localparam bit GATED = (REGN != int'(rtc_value_pkg::REG_MIN_SEC));
         always_comb begin
            field_wr[gi] = commit && (int'(sel_reg) == REGN) && pstrb[LSB / 8]
                           && (!GATED || calendar_write_unlock);
         end
         bcd_digit_store #(
            .WIDTH (rtc_value_pkg::FIELD_WIDTH[gi]),
            .MAX   (rtc_value_pkg::FIELD_MAX[gi])
         ) u_digit (
            .pclk    (pclk),
            .presetn (presetn),
            .wr_en   (field_wr[gi]),
            .wr_data (pwdata[LSB +: 4]),
            .value   (field_value[gi])
         );
      end
   endgenerate

   // Bus answer: one wait state, so read data is registered like every output
   always_comb begin
      next_pready  = psel && penable && !pready;
      next_pslverr = 1'b0;
      next_prdata  = 32'h0000_0000;
      if (psel && penable && !pready) begin
         next_pslverr = !mapped;
         if (!pwrite) begin
            case (sel_reg)
               rtc_value_pkg::REG_WKDY_HOURS:    next_prdata = {16'h0000, wkdy_word};
               rtc_value_pkg::REG_MIN_SEC:       next_prdata = {16'h0000, min_sec_word};
               rtc_value_pkg::REG_ALARM_MTH_DAY: next_prdata = {16'h0000, alarm_word};
               default: begin
                  if (sel_ctrl) begin
                     next_prdata[rtc_value_pkg::UNLOCK_BIT] = calendar_write_unlock;
                  end
               end
            endcase
         end
      end
   end

   // Unlock bit written through the control word
   always_comb begin
      next_unlock = calendar_write_unlock;
      if (commit && sel_ctrl && pstrb[0]) begin
         next_unlock = pwdata[rtc_value_pkg::UNLOCK_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready                <= 1'b0;
         pslverr               <= 1'b0;
         prdata                <= 32'h0000_0000;
         calendar_write_unlock <= rtc_value_pkg::UNLOCK_RESET;
      end else begin
         pready                <= next_pready;
         pslverr               <= next_pslverr;
         prdata                <= next_prdata;
         calendar_write_unlock <= next_unlock;
      end
   end

   // Value ports mirror the digit flops directly
   assign weekday_hours_value   = wkdy_word;
   assign minutes_seconds_value = min_sec_word;
   assign alarm_month_day_value = alarm_word;

   // Checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   logic locked_wkdy_wr;
   logic locked_alarm_wr;
   logic open_alarm_hi_wr;
   logic open_min_wr;
   logic open_hours_wr;
   logic open_alarm_lo_wr;
   logic sec_wr;

   assign locked_wkdy_wr   = commit && (sel_reg == rtc_value_pkg::REG_WKDY_HOURS)
                             && !calendar_write_unlock;
   assign locked_alarm_wr  = commit && (sel_reg == rtc_value_pkg::REG_ALARM_MTH_DAY)
                             && !calendar_write_unlock;
   assign open_alarm_hi_wr = commit && (sel_reg == rtc_value_pkg::REG_ALARM_MTH_DAY)
                             && calendar_write_unlock && pstrb[1];
   assign open_min_wr      = commit && (sel_reg == rtc_value_pkg::REG_MIN_SEC)
                             && pstrb[1] && (pwdata[14:12] <= 3'h5)
                             && (pwdata[11:8] <= 4'h9);
   assign open_hours_wr    = commit && (sel_reg == rtc_value_pkg::REG_WKDY_HOURS)
                             && calendar_write_unlock;
   assign open_alarm_lo_wr = commit && (sel_reg == rtc_value_pkg::REG_ALARM_MTH_DAY)
                             && calendar_write_unlock && pstrb[0];
   assign sec_wr           = commit && (sel_reg == rtc_value_pkg::REG_MIN_SEC) && pstrb[0];

   chk_lock_hold_hours: assert property (
      locked_wkdy_wr |=> $stable(weekday_hours_value))
      else $error("weekday/hours changed while locked");

   chk_lock_hold_alarm: assert property (
      locked_alarm_wr |=> $stable(alarm_month_day_value))
      else $error("alarm month/day changed while locked");

   chk_min_tens_load: assert property (
      open_min_wr |=> minutes_seconds_value[14:12] == $past(pwdata[14:12]))
      else $error("minute tens digit not loaded from bits 14-12");

   chk_min_ones_load: assert property (
      open_min_wr |=> minutes_seconds_value[11:8] == $past(pwdata[11:8]))
      else $error("minute ones digit not loaded from bits 11-8");

   chk_min_sec_range: assert property (
      minutes_seconds_value[14:12] <= 3'h5 && minutes_seconds_value[11:8] <= 4'h9)
      else $error("minute digit out of range");

   chk_sec_tens_range: assert property (
      minutes_seconds_value[6:4] <= 3'h5)
      else $error("second tens digit out of range");

   chk_sec_ones_range: assert property (
      minutes_seconds_value[3:0] <= 4'h9)
      else $error("second ones digit out of range");

   chk_amonth_tens_load: assert property (
      open_alarm_hi_wr && (pwdata[11:8] <= 4'h9)
      |=> alarm_month_day_value[12] == $past(pwdata[12]))
      else $error("alarm month tens bit not loaded");

   chk_alarm_ranges: assert property (
      alarm_month_day_value[11:8] <= 4'h9 && alarm_month_day_value[3:0] <= 4'h9)
      else $error("alarm ones digit out of range");

   chk_aday_tens_range: assert property (
      alarm_month_day_value[5:4] <= 2'h3)
      else $error("alarm day tens digit out of range");

   chk_aday_ones_range: assert property (
      alarm_month_day_value[3:0] <= 4'h9)
      else $error("alarm day ones digit out of range");

   chk_weekday_range: assert property (
      weekday_hours_value[10:8] <= 3'h6)
      else $error("weekday out of range");

   chk_hour_tens_range: assert property (
      weekday_hours_value[5:4] <= 2'h2)
      else $error("hour tens digit out of range");

   chk_unused_zero: assert property (
      minutes_seconds_value[15] == 1'b0 && minutes_seconds_value[7] == 1'b0
      && alarm_month_day_value[15:13] == 3'h0 && alarm_month_day_value[7:6] == 2'h0
      && weekday_hours_value[15:11] == 5'h00 && weekday_hours_value[7:6] == 2'h0)
      else $error("unused value bit reads nonzero");

   chk_ready_one_cycle: assert property (
      psel && penable && !pready |=> pready ##1 !pready)
      else $error("pready not a single-cycle answer");

   chk_read_data_word: assert property (
      psel && penable && !pready && !pwrite && sel_reg == rtc_value_pkg::REG_MIN_SEC
      |=> prdata == {16'h0000, $past(min_sec_word)})
      else $error("minutes/seconds read data wrong");

   chk_weekday_load: assert property (
      open_hours_wr && pstrb[1] && pwdata[10:8] <= 3'h6
      |=> weekday_hours_value[10:8] == $past(pwdata[10:8]))
      else $error("weekday not loaded from bits 10-8");

   // Code 7 fits the field, so only the range guard keeps it out
   chk_weekday_reject: assert property (
      open_hours_wr && pstrb[1] && pwdata[10:8] == 3'h7
      |=> $stable(weekday_hours_value[10:8]))
      else $error("illegal weekday code stored");

   chk_hour_tens_load: assert property (
      open_hours_wr && pstrb[0] && pwdata[5:4] <= 2'h2
      |=> weekday_hours_value[5:4] == $past(pwdata[5:4]))
      else $error("hour tens digit not loaded from bits 5-4");

   chk_sec_tens_load: assert property (
      sec_wr && pwdata[6:4] <= 3'h5
      |=> minutes_seconds_value[6:4] == $past(pwdata[6:4]))
      else $error("second tens digit not loaded from bits 6-4");

   chk_sec_ones_load: assert property (
      sec_wr && pwdata[3:0] <= 4'h9
      |=> minutes_seconds_value[3:0] == $past(pwdata[3:0]))
      else $error("second ones digit not loaded from bits 3-0");

   chk_min_ones_reject: assert property (
      commit && sel_reg == rtc_value_pkg::REG_MIN_SEC && pstrb[1] && pwdata[11:8] > 4'h9
      |=> $stable(minutes_seconds_value[11:8]))
      else $error("illegal minute ones digit stored");

   chk_lane_hold: assert property (
      commit && sel_reg == rtc_value_pkg::REG_MIN_SEC && !pstrb[1]
      |=> $stable(minutes_seconds_value[15:8]))
      else $error("minute digits changed without their byte strobe");

   chk_amonth_ones_load: assert property (
      open_alarm_hi_wr && pwdata[11:8] <= 4'h9
      |=> alarm_month_day_value[11:8] == $past(pwdata[11:8]))
      else $error("alarm month ones digit not loaded");

   chk_aday_tens_load: assert property (
      open_alarm_lo_wr && pwdata[5:4] <= 2'h3
      |=> alarm_month_day_value[5:4] == $past(pwdata[5:4]))
      else $error("alarm day tens digit not loaded");

   chk_aday_ones_load: assert property (
      open_alarm_lo_wr && pwdata[3:0] <= 4'h9
      |=> alarm_month_day_value[3:0] == $past(pwdata[3:0]))
      else $error("alarm day ones digit not loaded");

   chk_unlock_write: assert property (
      commit && sel_ctrl && pstrb[0]
      |=> calendar_write_unlock == $past(pwdata[rtc_value_pkg::UNLOCK_BIT]))
      else $error("unlock bit not taken from the control word");

   chk_unmapped_error: assert property (
      psel && penable && !pready && !mapped |=> pready && pslverr)
      else $error("unmapped access not answered with an error");

   // Read data is only driven in the answer cycle, so a stale word never leaks
   chk_idle_quiet: assert property (
      !pready |-> prdata == 32'h0000_0000 && !pslverr)
      else $error("bus answer outputs not quiet between transfers");

   cov_unlocked_hours_wr: cover property (
      commit && sel_reg == rtc_value_pkg::REG_WKDY_HOURS && calendar_write_unlock);
   cov_locked_alarm_wr: cover property (locked_alarm_wr);
   cov_min_sec_read: cover property (
      pready && !pwrite && sel_reg == rtc_value_pkg::REG_MIN_SEC);
   cov_unmapped_error: cover property (pready && pslverr);
   cov_unlock_set: cover property (commit && sel_ctrl && pstrb[0] && pwdata[0]);

endmodule // rtc_value_regs

// ==== sim/rtc_value_regs_tb_top.sv ====
// Self-checking bench for the calendar value register block over APB.
// Assumes the one-wait-state APB slave and the offsets of rtc_value_pkg.
`timescale 1ns/1ps
module rtc_value_regs_tb_top;
   typedef struct packed {logic rd; logic err; logic [31:0] data;} note_t;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        calendar_write_unlock, unlock_m;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  pstrb;
   logic [15:0] weekday_hours_value, minutes_seconds_value, alarm_month_day_value;
   logic [15:0] model [3];
   note_t       notes [$];
   note_t       nt;
   int          err_total, n_checks, cyc, idx, v;
   integer      seed = 32'h4d165004;

   rtc_value_regs i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .calendar_write_unlock(calendar_write_unlock),
      .weekday_hours_value(weekday_hours_value),
      .minutes_seconds_value(minutes_seconds_value),
      .alarm_month_day_value(alarm_month_day_value)
   );

   always #2 pclk = ~pclk;

   task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic summarize;
      $display("checks=%0d mismatches=%0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Reference for one value word: a digit lands only if its lane is strobed and in range
   function automatic logic [15:0] upd(int r, logic [15:0] old, logic [31:0] d,
                                       logic [3:0] s);
      logic [15:0] w;
      int          lsb, wid, dv;
      w = old;
      for (int f = 0; f < rtc_value_pkg::NUM_FIELDS; f++) begin
         lsb = rtc_value_pkg::FIELD_LSB[f];
         wid = rtc_value_pkg::FIELD_WIDTH[f];
         dv = int'((d >> lsb) & ((32'h1 << wid) - 32'h1));
         if (rtc_value_pkg::FIELD_REG[f] == r && s[lsb / 8] && dv <= rtc_value_pkg::FIELD_MAX[f])
            for (int b = 0; b < wid; b++) w[lsb + b] = dv[b];
      end
      return w;
   endfunction

   // Index 0 is control, 1..3 the value words, 4 an unmapped place
   task automatic apb(input logic w, input int i, input logic [31:0] d, input logic [3:0] s);
      note_t n;
      n.rd = ~w;
      n.err = (i > 3);
      n.data = 32'h0;
      if (i == 0) n.data = {31'h0, unlock_m};
      else if (i <= 3) n.data = {16'h0, model[i-1]};
      notes.push_back(n);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= 12'(i * 4);
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      // Request stands until pready is seen high at a rising edge, released right there
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      if (w && i == 0 && s[0]) unlock_m = d[0];
      if (w && i >= 1 && i <= 3 && (i == 2 || unlock_m)) model[i-1] = upd(i - 1, model[i-1], d, s);
      @(negedge pclk);
      chk({32'h0, calendar_write_unlock}, {32'h0, unlock_m});
      chk({17'h0, weekday_hours_value}, {17'h0, model[0]});
      chk({17'h0, minutes_seconds_value}, {17'h0, model[1]});
      chk({17'h0, alarm_month_day_value}, {17'h0, model[2]});
   endtask

   // Watcher: every answer retires the oldest note, at the edge the master takes it
   always @(posedge pclk) begin
      if (pready === 1'b1) begin
         if (notes.size() == 0) begin
            chk({1'b1, 32'h0}, 33'h0);
         end else begin
            nt = notes.pop_front();
            if (nt.rd) chk({pslverr, prdata}, {nt.err, nt.data});
            else chk({pslverr, prdata}, {nt.err, 32'h0});
         end
      end
   end

   // Runs need about 860 cycles; the ceiling leaves wide margin
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, cyc, 0);
         summarize;
      end
   end

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      model = '{default: 16'h0};
      unlock_m = 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 5; i++) apb(1'b0, i, 32'h0, 4'h0);
      // Locked: the two gated words must not move, min/sec must
      apb(1'b1, 1, 32'h0000_0123, 4'hf);
      apb(1'b1, 3, 32'h0000_1129, 4'hf);
      apb(1'b1, 2, 32'hffff_0559, 4'hf);
      apb(1'b1, 0, 32'h1, 4'hf);
      // Each digit at its top value, then one past it where the field can hold that
      for (int f = 0; f < rtc_value_pkg::NUM_FIELDS; f++) begin
         for (int k = 0; k < 2; k++) begin
            v = rtc_value_pkg::FIELD_MAX[f] + k;
            idx = rtc_value_pkg::FIELD_REG[f] + 1;
            if (v < (1 << rtc_value_pkg::FIELD_WIDTH[f])) begin
               apb(1'b1, idx, 32'(v) << rtc_value_pkg::FIELD_LSB[f], 4'h3);
               apb(1'b0, idx, 32'h0, 4'h0);
            end
         end
      end
      // Random data and strobes, unlock toggling, unused bits and the unmapped place
      repeat (80) begin
         idx = int'($unsigned($random(seed)) % 5);
         apb(1'b1, idx, $random(seed), 4'($random(seed)));
         apb(1'b0, idx, 32'h0, 4'h0);
      end
      // Second reset in mid-run clears every word and relocks
      @(posedge pclk);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      model = '{default: 16'h0};
      unlock_m = 1'b0;
      for (int i = 0; i < 4; i++) apb(1'b0, i, 32'h0, 4'h0);
      summarize;
   end
endmodule // rtc_value_regs_tb_top
